/* hw/gpk_port.sv */
// Two-bit port with CEC, clock and alarm alternate functions behind APB
`timescale 1ns/1ps
module gpk_port
    import gpk_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pin 0, open drain
    input wire logic pin0_i,
    output logic pin0_o,
    output logic pin0_oe,
    // Pin 1, push-pull with pull-up
    input wire logic pin1_i,
    output logic pin1_o,
    output logic pin1_oe,
    output logic pin1_pullup_en,
    // Alternate-function peripherals
    input wire logic cec_tx_level,
    output logic cec_rx,
    input wire logic system_clock_output,
    input wire logic alarm_n
);

    // Registered state and its next value
    gpk_state_s st_reg;
    gpk_state_s st_next;

    // Access phase of a write
    logic wr_en;
    // Setup phase of any transfer
    logic setup;
    // Pin levels after the input gates
    logic [1:0] pin_seen;
    // Address hits a mapped register
    logic hit;
    // Read word before it is registered
    logic [31:0] rd_word;
    // Level the pin 0 stage asks for
    logic pin0_level;

    // Zero-wait slave: every access phase ends in one cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign setup = psel && !penable;

    // Input gates follow the second synchroniser stage only
    assign pin_seen = st_reg.sync2 & st_reg.ien[1:0];

    // Address decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_word = GPK_WORD_ZERO;
        unique case (paddr)
            GPK_OFF_PIN_DATA: begin
                // Pins read back through their input gates
                rd_word[GPK_BIT_PIN1:GPK_BIT_PIN0] = pin_seen;
                rd_word[GPK_BIT_RSVD] = st_reg.dat[GPK_BIT_RSVD];
            end
            GPK_OFF_OUTPUT_ENABLE: begin
                // Driver enables, bit 2 kept as stored
                rd_word[2:0] = st_reg.oen;
            end
            GPK_OFF_FUNCTION_SELECT_ONE: begin
                // Clock and CEC selects, bit 2 kept as stored
                rd_word[2:0] = st_reg.fs1;
            end
            GPK_OFF_FUNCTION_SELECT_TWO: begin
                // Only the alarm select bit exists
                rd_word[2:0] = st_reg.fs2 & GPK_MASK_FS2;
            end
            GPK_OFF_PULLUP_CONTROL: begin
                // Pin 0 has no pull-up
                rd_word[2:0] = st_reg.pup & GPK_MASK_PUP;
            end
            GPK_OFF_INPUT_ENABLE: begin
                // Input gates, bit 2 kept as stored
                rd_word[2:0] = st_reg.ien;
            end
            default: begin
                // Unmapped word answers with an error
                hit = 1'b0;
            end
        endcase
    end

    // Next-state logic
    always_comb begin
        st_next = st_reg;

        // Two-stage synchroniser on both pins
        st_next.sync1 = {pin1_i, pin0_i};
        st_next.sync2 = st_reg.sync1;

        // Read data and error are loaded in the setup phase
        if (setup) begin
            st_next.prdata = rd_word;
            st_next.pslverr = !hit;
        end

        // Writes land at the access-phase edge
        if (wr_en && hit) begin
            unique case (paddr)
                GPK_OFF_PIN_DATA: begin
                    // Output latch only; the read path shows the pins
                    st_next.dat = pwdata[2:0];
                end
                GPK_OFF_OUTPUT_ENABLE: begin
                    // Driver enables reach the pins one edge later
                    st_next.oen = pwdata[2:0];
                end
                GPK_OFF_FUNCTION_SELECT_ONE: begin
                    st_next.fs1 = pwdata[2:0];
                end
                GPK_OFF_FUNCTION_SELECT_TWO: begin
                    st_next.fs2 = pwdata[2:0] & GPK_MASK_FS2;
                end
                GPK_OFF_PULLUP_CONTROL: begin
                    st_next.pup = pwdata[2:0] & GPK_MASK_PUP;
                end
                GPK_OFF_INPUT_ENABLE: begin
                    st_next.ien = pwdata[2:0];
                end
                default: begin
                    // Decode already refused other addresses
                    st_next.dat = st_reg.dat;
                end
            endcase
        end

        // Pin 0 level: CEC transmitter or port data
        pin0_level = st_reg.fs1[GPK_BIT_PIN0] ? cec_tx_level : st_reg.dat[GPK_BIT_PIN0];
        // Open drain: pull down only for a low level
        st_next.pin0_oe = st_reg.oen[GPK_BIT_PIN0] && !pin0_level;

        // Pin 1 source: alarm first, then clock, then port data
        if (st_reg.fs2[GPK_BIT_PIN1]) begin
            st_next.pin1_o = alarm_n;
        end else if (st_reg.fs1[GPK_BIT_PIN1]) begin
            st_next.pin1_o = system_clock_output;
        end else begin
            st_next.pin1_o = st_reg.dat[GPK_BIT_PIN1];
        end
        st_next.pin1_oe = st_reg.oen[GPK_BIT_PIN1];

        // CEC receiver sees the gated pin 0 level when selected
        st_next.cec_rx = pin_seen[GPK_BIT_PIN0] && st_reg.fs1[GPK_BIT_PIN0];
    end

    // State register with asynchronous clear to the reset record
    // Only constants are loaded while reset is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= GPK_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs from the state register, except the constant pin 0 level
    assign prdata = st_reg.prdata;
    assign pslverr = st_reg.pslverr;
    // Pin 0 never drives high; only its enable moves
    assign pin0_o = 1'b0;
    assign pin0_oe = st_reg.pin0_oe;
    assign pin1_o = st_reg.pin1_o;
    assign pin1_oe = st_reg.pin1_oe;
    assign cec_rx = st_reg.cec_rx;

    // Pull-up gated by reset itself, not only by the register
    assign pin1_pullup_en = presetn && st_reg.pup[GPK_BIT_PIN1];

    // Checks: all run on the bus clock; all but the pull-up reset check rest while reset is low
    // Pin driver checks look one edge after the register bit and two after the bus write, since driver outputs are registered; pull-up checks look in the same cycle
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Setup of a read at a given address
    sequence s_rd(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    // Access phase of a write at a given address
    sequence s_wr(logic [11:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence

    property p_rsvd_zero;
        psel && !penable |=> prdata[31:3] == 29'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("upper bits not zero");

    property p_oe_write;
        s_wr(GPK_OFF_OUTPUT_ENABLE) |=> ##1 pin1_oe == $past(pwdata[1], 2);
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("pin 1 enable wrong");

    property p_clk_route;
        st_reg.fs1[1] && !st_reg.fs2[1] |=> pin1_o == $past(system_clock_output);
    endproperty
    a_clk_route: assert property (p_clk_route) else $error("clock not routed");

    property p_alarm_route;
        st_reg.fs2[1] |=> pin1_o == $past(alarm_n);
    endproperty
    a_alarm_route: assert property (p_alarm_route) else $error("alarm not routed");

    property p_fs2_bit0;
        s_rd(GPK_OFF_FUNCTION_SELECT_TWO) |=> prdata[0] == 1'b0;
    endproperty
    a_fs2_bit0: assert property (p_fs2_bit0) else $error("select two bit 0 set");

    property p_pup_bit0;
        s_rd(GPK_OFF_PULLUP_CONTROL) |=> prdata[0] == 1'b0;
    endproperty
    a_pup_bit0: assert property (p_pup_bit0) else $error("pull-up bit 0 set");

    property p_cec_gate;
        !st_reg.ien[0] |=> !cec_rx;
    endproperty
    a_cec_gate: assert property (p_cec_gate) else $error("cec input not gated");

    property p_pup_reset;
        @(posedge pclk) disable iff (1'b0) !presetn |-> !pin1_pullup_en;
    endproperty
    a_pup_reset: assert property (p_pup_reset) else $error("pull-up on in reset");

    property p_open_drain;
        pin0_oe |-> pin0_o == 1'b0 && $past(st_reg.oen[0]) && !$past(pin0_level);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin 0 drove high");

    property p_reset_idle;
        $rose(presetn) |-> !pin0_oe && !pin1_oe && !pin1_pullup_en && st_reg.ien == 3'h0;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins not idle");

    property p_data_read;
        s_rd(GPK_OFF_PIN_DATA) |=> prdata[1:0] == $past(pin_seen);
    endproperty
    a_data_read: assert property (p_data_read) else $error("data read wrong");

    // A write to the data register lands at the access edge
    property p_wr_dat;
        s_wr(GPK_OFF_PIN_DATA) |=> st_reg.dat == $past(pwdata[2:0]);
    endproperty
    a_wr_dat: assert property (p_wr_dat) else $error("data write lost");

    // A read of the hole in the map answers with an error and a zero word
    property p_unmapped;
        s_rd(12'h010) |=> pslverr && prdata == GPK_WORD_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");

    // A mapped read answers without error and with the stored gates
    property p_mapped_ok;
        s_rd(GPK_OFF_INPUT_ENABLE) |=> !pslverr && prdata[2:0] == $past(st_reg.ien);
    endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped read refused");

    // A disabled pin 0 driver never pulls the line
    property p_pin0_off;
        !st_reg.oen[0] |=> !pin0_oe;
    endproperty
    a_pin0_off: assert property (p_pin0_off) else $error("pin 0 pulled while off");

    // Pin 1 driver enable follows its register bit one edge later
    property p_pin1_oe;
        1'b1 |=> pin1_oe == $past(st_reg.oen[1]);
    endproperty
    a_pin1_oe: assert property (p_pin1_oe) else $error("pin 1 enable lags");

    // The CEC transmitter level steers the pin 0 pull-down
    property p_cec_route;
        st_reg.fs1[0] && st_reg.oen[0] |=> pin0_oe == !$past(cec_tx_level);
    endproperty
    a_cec_route: assert property (p_cec_route) else $error("cec not routed");

    // With neither select set, pin 1 carries the port data bit
    property p_port_route;
        !st_reg.fs1[1] && !st_reg.fs2[1] |=> pin1_o == $past(st_reg.dat[1]);
    endproperty
    a_port_route: assert property (p_port_route) else $error("port data not routed");

    // Select two keeps only its alarm bit
    property p_fs2_store;
        !st_reg.fs2[2] && !st_reg.fs2[0];
    endproperty
    a_fs2_store: assert property (p_fs2_store) else $error("select two bit stored");

    // Pull-up output follows its stored bit outside reset
    property p_pup_follow;
        pin1_pullup_en == st_reg.pup[1];
    endproperty
    a_pup_follow: assert property (p_pup_follow) else $error("pull-up not following");

    // The missing pin 0 pull-up bit is never stored
    property p_pup_store;
        !st_reg.pup[0];
    endproperty
    a_pup_store: assert property (p_pup_store) else $error("pin 0 pull-up stored");

    // An input-enable write lands at the access edge
    property p_wr_ien;
        s_wr(GPK_OFF_INPUT_ENABLE) |=> st_reg.ien == $past(pwdata[2:0]);
    endproperty
    a_wr_ien: assert property (p_wr_ien) else $error("input enable write lost");

    // A disabled pin 1 input path reads back zero
    property p_in_gate1;
        s_rd(GPK_OFF_PIN_DATA) ##0 !st_reg.ien[1] |=> !prdata[1];
    endproperty
    a_in_gate1: assert property (p_in_gate1) else $error("pin 1 input not gated");

    // Port mode on pin 0: a zero bit pulls low, a one releases
    property p_pin0_port;
        !st_reg.fs1[0] && st_reg.oen[0] |=> pin0_oe == !$past(st_reg.dat[0]);
    endproperty
    a_pin0_port: assert property (p_pin0_port) else $error("pin 0 port level wrong");

    // Both pin levels pass exactly two flip-flops before use
    property p_sync_depth;
        $past(presetn) |=> st_reg.sync2 == $past({pin1_i, pin0_i}, 2);
    endproperty
    a_sync_depth: assert property (p_sync_depth) else $error("sync depth wrong");

endmodule : gpk_port

/* hw/gpk_pkg.sv */
// Package for the two-bit port: register map, field positions and the state record
package gpk_pkg;

    // Register byte offsets
    localparam logic [11:0] GPK_OFF_PIN_DATA = 12'h000;
    localparam logic [11:0] GPK_OFF_OUTPUT_ENABLE = 12'h004;
    localparam logic [11:0] GPK_OFF_FUNCTION_SELECT_ONE = 12'h008;
    localparam logic [11:0] GPK_OFF_FUNCTION_SELECT_TWO = 12'h00c;
    localparam logic [11:0] GPK_OFF_PULLUP_CONTROL = 12'h02c;
    localparam logic [11:0] GPK_OFF_INPUT_ENABLE = 12'h038;

    // Field positions
    localparam int GPK_BIT_PIN0 = 0;
    localparam int GPK_BIT_PIN1 = 1;
    localparam int GPK_BIT_RSVD = 2;

    // Stored field width: two pin bits plus the write-zero reserved bit
    localparam int GPK_FW = 3;

    // Writable masks per register
    localparam logic [2:0] GPK_MASK_FULL = 3'h7;
    localparam logic [2:0] GPK_MASK_FS2 = 3'h2;
    localparam logic [2:0] GPK_MASK_PUP = 3'h6;

    // Value after reset of every field
    localparam logic [2:0] GPK_FIELD_RST = 3'h0;
    localparam logic [31:0] GPK_WORD_ZERO = 32'h0000_0000;

    // Every stored bit of the block
    typedef struct packed {
        logic [2:0] dat;      // Pin data latch
        logic [2:0] oen;      // Output enables
        logic [2:0] fs1;      // Function select one
        logic [2:0] fs2;      // Function select two
        logic [2:0] pup;      // Pull-up control
        logic [2:0] ien;      // Input enables
        logic [1:0] sync1;    // First synchroniser stage
        logic [1:0] sync2;    // Second synchroniser stage
        logic pin0_oe;        // Open-drain pull-down enable
        logic pin1_o;         // Pin 1 output level
        logic pin1_oe;        // Pin 1 driver enable
        logic cec_rx;         // Line level seen by the CEC unit
        logic [31:0] prdata;  // Read data
        logic pslverr;        // Error answer
    } gpk_state_s;

    localparam gpk_state_s GPK_STATE_RST = '0;

endpackage : gpk_pkg

/* dv/gpk_pins.sv */
// Far-side model of the two port pins and the boards lines behind them
`timescale 1ns/1ps
module gpk_pins (
    // Pad controls from the port
    input wire logic pin0_oe,
    input wire logic pin1_o,
    input wire logic pin1_oe,
    input wire logic pin1_pullup_en,
    // Other devices on the lines
    input wire logic ext0_low,
    input wire logic ext1_lvl,
    // Line levels back to the port
    output logic pin0_i,
    output logic pin1_i
);
    // Pin 0 line idles high through a board resistor; anyone may pull it low
    assign pin0_i = !(pin0_oe || ext0_low);
    // Pin 1: own driver first, then the pull-up, else the outside level
    assign pin1_i = pin1_oe ? pin1_o : (pin1_pullup_en ? 1'b1 : ext1_lvl);
endmodule : gpk_pins

/* dv/tb_gpk_port.sv */
// Self-checking bench for the two-bit port
`timescale 1ns/1ps
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin err_count++; \
    $display("ERROR %s exp %h got %h", n, e, v); end end
module tb_gpk_port import gpk_pkg::*; ;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, errv;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic pready, pslverr, pin0_i, pin0_o, pin0_oe, pin1_i, pin1_o, pin1_oe, pup_en, cec_rx;
    // Alternate sources and outside line levels
    logic cec_tx = 1, sclk = 0, alarm_n = 1, ext0 = 0, ext1 = 0;
    int err_count = 0, checks = 0, mdl[6] = '{0, 0, 0, 0, 0, 0};
    logic [11:0] adr[6] = '{GPK_OFF_PIN_DATA, GPK_OFF_OUTPUT_ENABLE,
        GPK_OFF_FUNCTION_SELECT_ONE, GPK_OFF_FUNCTION_SELECT_TWO,
        GPK_OFF_PULLUP_CONTROL, GPK_OFF_INPUT_ENABLE};
    int msk[6] = '{3, 3, 3, 2, 2, 3};
    always #2.5 pclk = ~pclk;
    gpk_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin0_i(pin0_i), .pin0_o(pin0_o), .pin0_oe(pin0_oe),
        .pin1_i(pin1_i), .pin1_o(pin1_o), .pin1_oe(pin1_oe), .pin1_pullup_en(pup_en),
        .cec_tx_level(cec_tx), .cec_rx(cec_rx), .system_clock_output(sclk),
        .alarm_n(alarm_n));
    gpk_pins far (.pin0_oe(pin0_oe), .pin1_o(pin1_o), .pin1_oe(pin1_oe),
        .pin1_pullup_en(pup_en), .ext0_low(ext0), .ext1_lvl(ext1), .pin0_i(pin0_i),
        .pin1_i(pin1_i));
    // Print the counts and the verdict, then stop
    task automatic test_done();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    // One APB transfer; data and error are taken at the pready edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Write a register and keep the model copy
    task automatic wr(input int i, input logic [31:0] d);
        mdl[i] = d & msk[i];
        apb(1'b1, adr[i], d);
    endtask : wr
    // Read a control register against the model
    task automatic rd_chk(input int i);
        apb(1'b0, adr[i], '0);
        `CHK("register", 32'(mdl[i]), rdv)
        `CHK("mapped slverr", 1'b0, errv)
    endtask : rd_chk
    // Let pins settle, then compare every pin output and the data read
    task automatic chk_all();
        logic o1, oe0, p0, p1;
        repeat (4) @(posedge pclk);
        #1;
        o1 = mdl[3][1] ? alarm_n : (mdl[2][1] ? sclk : mdl[0][1]);
        oe0 = mdl[1][0] && !(mdl[2][0] ? cec_tx : mdl[0][0]);
        p0 = !(oe0 || ext0);
        p1 = mdl[1][1] ? o1 : (mdl[4][1] ? 1'b1 : ext1);
        `CHK("pin0_o", 1'b0, pin0_o)
        `CHK("pin0_oe", oe0, pin0_oe)
        `CHK("pin1_oe", mdl[1][1], pin1_oe)
        `CHK("pin1_o", o1, pin1_o)
        `CHK("pullup", mdl[4][1], pup_en)
        `CHK("cec_rx", mdl[5][0] & mdl[2][0] & p0, cec_rx)
        apb(1'b0, adr[0], '0);
        `CHK("data", {30'h0, p1 & mdl[5][1], p0 & mdl[5][0]}, rdv)
    endtask : chk_all
    initial begin
        void'($urandom(29347));
        #1;
        `CHK("pullup before first edge", 1'b0, pup_en)
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk_all();
        for (int i = 1; i < 6; i++) rd_chk(i);
        // Hole in the map is refused
        apb(1'b0, 12'h010, '0);
        `CHK("slverr", 1'b1, errv)
        `CHK("unmapped", 32'h0, rdv)
        `CHK("pready", 1'b1, pready)
        // Random setups over every select, enable and line level
        for (int k = 0; k < 40; k++) begin
            for (int i = 0; i < 6; i++) wr(i, $urandom() & 32'hffff_fffb);
            {cec_tx, sclk, alarm_n, ext0, ext1} <= 5'($urandom());
            chk_all();
            for (int i = 1; i < 6; i++) rd_chk(i);
        end
        // Pull-up dropped while reset is held
        wr(4, 32'h2);
        chk_all();
        presetn <= 1'b0;
        #1;
        `CHK("pullup in reset", 1'b0, pup_en)
        repeat (2) @(posedge pclk);
        `CHK("pullup held", 1'b0, pup_en)
        presetn <= 1'b1;
        foreach (mdl[i]) mdl[i] = 0;
        chk_all();
        test_done();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #50000;
        err_count++;
        test_done();
    end
endmodule : tb_gpk_port
